// File: core/hspmc_defs.svh
/*
  Constants of the host serial port and mode control block: register
  offsets, field positions, reset values and bit-time counts.
  Assumes a 250 MHz system clock and a 32-bit classic Wishbone slave.
*/
`ifndef HSPMC_DEFS_SVH
`define HSPMC_DEFS_SVH

`define HSPMC_CLK_HZ 250000000
`define HSPMC_BAUD_FAST 19200
`define HSPMC_BAUD_SLOW 9600
`define HSPMC_BAUD_PROG 9600
`define HSPMC_DIV_FAST (`HSPMC_CLK_HZ / `HSPMC_BAUD_FAST)
`define HSPMC_DIV_SLOW (`HSPMC_CLK_HZ / `HSPMC_BAUD_SLOW)
`define HSPMC_DIV_PROG (`HSPMC_CLK_HZ / `HSPMC_BAUD_PROG)
`define HSPMC_DIV_W 16

`define HSPMC_ADR_CTRL 4'h0
`define HSPMC_ADR_STAT 4'h1
`define HSPMC_ADR_TXD 4'h2
`define HSPMC_ADR_RXD 4'h3
`define HSPMC_ADR_FEAT 4'h4

`define HSPMC_CTRL_P1EN 0
`define HSPMC_CTRL_P2EN 1
`define HSPMC_CTRL_STOP2 2
`define HSPMC_CTRL_RTSUSE 3
`define HSPMC_CTRL_CTSFORCE 4
`define HSPMC_CTRL_W 5
`define HSPMC_CTRL_RST 5'h11

`define HSPMC_FEAT_W 7
`define HSPMC_FEAT_RST 7'h00

`define HSPMC_STAT_RXV 0
`define HSPMC_STAT_TXRDY 1
`define HSPMC_STAT_PROG 2
`define HSPMC_STAT_STBY 3
`define HSPMC_STAT_P2IF 4
`define HSPMC_STAT_SLOW 5
`define HSPMC_STAT_RXERR 6

`define HSPMC_BITS 8
`define HSPMC_BIT_CNT_W 4

`endif

// File: core/hspmc_pkg.sv
/*
  Types of the host serial port and mode control block.
  Assumes hspmc_defs.svh for all numeric constants.
*/
package hspmc_pkg;
  typedef enum logic [3:0] {
    HSPMC_SER_IDLE = 4'h1,
    HSPMC_SER_START = 4'h2,
    HSPMC_SER_DATA = 4'h4,
    HSPMC_SER_STOP = 4'h8
  } hspmc_ser_t;
endpackage : hspmc_pkg

// File: core/hspmc_buf_if.sv
/*
  Valid/ready byte channel between the top block and its buffer.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/10ps
interface hspmc_buf_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : hspmc_buf_if

// File: core/hspmc_buf2.sv
/*
  Two-entry buffer with valid/ready on both sides.
  Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
module hspmc_buf2 (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_flush,
  hspmc_buf_if.snk in_ch,
  hspmc_buf_if.src out_ch
);
  typedef struct packed {
    logic [1:0][7:0] mem;
    logic rd;
    logic wr;
    logic [1:0] cnt;
  } hspmc_buf_st_t;

  hspmc_buf_st_t st_ff;
  hspmc_buf_st_t nxt_st;
  logic push;
  logic pop;

  assign in_ch.ready = (st_ff.cnt != 2'h2) && !i_flush;
  assign out_ch.valid = (st_ff.cnt != 2'h0);
  assign out_ch.data = st_ff.mem[st_ff.rd];
  assign push = in_ch.valid && in_ch.ready;
  assign pop = out_ch.valid && out_ch.ready;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wr] = in_ch.data;
      nxt_st.wr = !st_ff.wr;
    end
    if (pop) begin
      nxt_st.rd = !st_ff.rd;
    end
    nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
    if (i_flush) begin
      nxt_st.cnt = 2'h0;
      nxt_st.rd = 1'b0;
      nxt_st.wr = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : hspmc_buf2

// File: core/hspmc_top.sv
/*
  Host serial port and operating-mode control of a radio data modem (DCE).
  Software reaches control, status and data over classic Wishbone.
  Assumes all pin inputs synchronous to I_SYS_CLK, active-high pin levels.
*/
// Local design decisions: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
`include "hspmc_defs.svh"
module hspmc_top (
  input wire logic I_SYS_CLK,
  input wire logic I_NRST,
  input wire logic I_TERM_READY,
  input wire logic I_MODE_NPROG,
  input wire logic I_NARROW_CH,
  input wire logic I_PORT2_RS485,
  input wire logic I_RSSI_ABOVE,
  input wire logic I_RTS,
  input wire logic I_TX_DATA_IN_FIRST_PORT,
  input wire logic I_TX_DATA_IN_SECOND_PORT,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [3:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  output logic O_RX_DATA_OUT_FIRST_PORT,
  output logic O_RX_DATA_OUT_SECOND_PORT,
  output logic O_CTS,
  output logic O_CD,
  output logic O_DSR
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [`HSPMC_CTRL_W-1:0] ctrl;
    logic [`HSPMC_FEAT_W-1:0] feat;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic rx_err;
    hspmc_pkg::hspmc_ser_t tx_st;
    logic [`HSPMC_DIV_W-1:0] tx_div;
    logic [`HSPMC_BIT_CNT_W-1:0] tx_cnt;
    logic [7:0] tx_sh;
    logic tx_line;
    logic tx_sel;
    hspmc_pkg::hspmc_ser_t rx_st;
    logic [`HSPMC_DIV_W-1:0] rx_div;
    logic [`HSPMC_BIT_CNT_W-1:0] rx_cnt;
    logic [7:0] rx_sh;
    logic rx_sel;
    logic p2_rs485;
    logic strap_done;
  } hspmc_st_t;

  hspmc_st_t st_ff;
  hspmc_st_t nxt_st;

  hspmc_buf_if wr_ch ();
  hspmc_buf_if tx_ch ();

  logic standby;
  logic prog_mode;
  logic use_p2;
  logic port_on;
  logic rx_in;
  logic [`HSPMC_DIV_W-1:0] bit_div;
  logic wb_req;
  logic [31:0] stat_word;

  // ************************************************************
  // mode and port selection
  // ************************************************************
  assign standby = !I_TERM_READY;
  assign prog_mode = !I_MODE_NPROG;
  // programming forces the first port; second port only when first is off
  assign use_p2 = !prog_mode && !st_ff.ctrl[`HSPMC_CTRL_P1EN]
    && st_ff.ctrl[`HSPMC_CTRL_P2EN];
  assign port_on = !standby && (prog_mode || st_ff.ctrl[`HSPMC_CTRL_P1EN]
    || st_ff.ctrl[`HSPMC_CTRL_P2EN]);
  assign rx_in = use_p2 ? I_TX_DATA_IN_SECOND_PORT : I_TX_DATA_IN_FIRST_PORT;

  // the programming speed overrides the channel strap
  always_comb begin
    if (prog_mode) begin
      bit_div = `HSPMC_DIV_W'(`HSPMC_DIV_PROG);
    end else if (I_NARROW_CH) begin
      bit_div = `HSPMC_DIV_W'(`HSPMC_DIV_SLOW);
    end else begin
      bit_div = `HSPMC_DIV_W'(`HSPMC_DIV_FAST);
    end
  end

  // ************************************************************
  // pins
  // ************************************************************
  // the idle port and a cut character both show the idle level
  assign O_RX_DATA_OUT_FIRST_PORT = (!use_p2 && !st_ff.tx_sel) ? st_ff.tx_line : 1'b1;
  assign O_RX_DATA_OUT_SECOND_PORT = (use_p2 && st_ff.tx_sel) ? st_ff.tx_line : 1'b1;
  // handshake pins are shared and independent of port choice
  assign O_CTS = !standby && (st_ff.ctrl[`HSPMC_CTRL_CTSFORCE]
    || (st_ff.ctrl[`HSPMC_CTRL_RTSUSE] ? I_RTS : wr_ch.ready));
  assign O_CD = !standby && I_RSSI_ABOVE;
  assign O_DSR = !standby;

  // ************************************************************
  // transmit buffer: software writes, serialiser drains
  // ************************************************************
  // no new request is taken while ack stands
  assign wb_req = I_WB_CYC && I_WB_STB && !st_ff.ack;
  assign wr_ch.valid = wb_req && I_WB_WE && (I_WB_ADR == `HSPMC_ADR_TXD) && I_WB_SEL[0];
  assign wr_ch.data = I_WB_DAT[7:0];
  assign tx_ch.ready = (st_ff.tx_st == hspmc_pkg::HSPMC_SER_IDLE) && port_on;

  // standby empties the buffer so no stale byte leaves later
  hspmc_buf2 u_txbuf (
    .i_clk(I_SYS_CLK),
    .i_nrst(I_NRST),
    .i_flush(standby),
    .in_ch(wr_ch),
    .out_ch(tx_ch)
  );

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`HSPMC_STAT_RXV] = st_ff.rx_valid;
    stat_word[`HSPMC_STAT_TXRDY] = wr_ch.ready;
    stat_word[`HSPMC_STAT_PROG] = prog_mode;
    stat_word[`HSPMC_STAT_STBY] = standby;
    stat_word[`HSPMC_STAT_P2IF] = st_ff.p2_rs485;
    stat_word[`HSPMC_STAT_SLOW] = I_NARROW_CH;
    stat_word[`HSPMC_STAT_RXERR] = st_ff.rx_err;
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = 1'b0;
    // strap caught once after reset release
    if (!st_ff.strap_done) begin
      nxt_st.p2_rs485 = I_PORT2_RS485;
      nxt_st.strap_done = 1'b1;
    end
    // wishbone slave: ack one cycle after request, tx data writes wait for buffer room
    // a full buffer stalls the write so no byte is dropped
    if (wb_req && (!wr_ch.valid || wr_ch.ready)) begin
      nxt_st.ack = 1'b1;
      nxt_st.rdat = 32'h0000_0000;
      case (I_WB_ADR)
        `HSPMC_ADR_CTRL: begin
          nxt_st.rdat[`HSPMC_CTRL_W-1:0] = st_ff.ctrl;
          if (I_WB_WE && I_WB_SEL[0]) begin
            nxt_st.ctrl = I_WB_DAT[`HSPMC_CTRL_W-1:0];
          end
        end
        `HSPMC_ADR_STAT: begin
          nxt_st.rdat = stat_word;
        end
        `HSPMC_ADR_RXD: begin
          nxt_st.rdat[7:0] = st_ff.rx_byte;
        end
        `HSPMC_ADR_FEAT: begin
          nxt_st.rdat[`HSPMC_FEAT_W-1:0] = st_ff.feat;
          if (I_WB_WE && I_WB_SEL[0]) begin
            nxt_st.feat = I_WB_DAT[`HSPMC_FEAT_W-1:0];
          end
        end
        default: begin
          nxt_st.rdat = 32'h0000_0000;
        end
      endcase
    end
    // transmit serialiser toward the terminal
    case (st_ff.tx_st)
      hspmc_pkg::HSPMC_SER_IDLE: begin
        nxt_st.tx_line = 1'b1;
        if (tx_ch.valid && tx_ch.ready) begin
          // load the byte and open the start bit at once
          nxt_st.tx_sh = tx_ch.data;
          nxt_st.tx_sel = use_p2;
          nxt_st.tx_div = bit_div;
          nxt_st.tx_line = 1'b0;
          nxt_st.tx_st = hspmc_pkg::HSPMC_SER_START;
        end
      end
      hspmc_pkg::HSPMC_SER_START: begin
        if (st_ff.tx_div == `HSPMC_DIV_W'(1)) begin
          nxt_st.tx_div = bit_div;
          nxt_st.tx_line = st_ff.tx_sh[0];
          nxt_st.tx_sh = {1'b0, st_ff.tx_sh[7:1]};
          nxt_st.tx_cnt = `HSPMC_BIT_CNT_W'(`HSPMC_BITS - 1);
          nxt_st.tx_st = hspmc_pkg::HSPMC_SER_DATA;
        end else begin
          nxt_st.tx_div = st_ff.tx_div - `HSPMC_DIV_W'(1);
        end
      end
      hspmc_pkg::HSPMC_SER_DATA: begin
        if (st_ff.tx_div == `HSPMC_DIV_W'(1)) begin
          nxt_st.tx_div = bit_div;
          if (st_ff.tx_cnt == `HSPMC_BIT_CNT_W'(0)) begin
            nxt_st.tx_line = 1'b1;
            // one stop bit unless two are selected
            nxt_st.tx_cnt = st_ff.ctrl[`HSPMC_CTRL_STOP2] ? `HSPMC_BIT_CNT_W'(1)
              : `HSPMC_BIT_CNT_W'(0);
            nxt_st.tx_st = hspmc_pkg::HSPMC_SER_STOP;
          end else begin
            nxt_st.tx_line = st_ff.tx_sh[0];
            nxt_st.tx_sh = {1'b0, st_ff.tx_sh[7:1]};
            nxt_st.tx_cnt = st_ff.tx_cnt - `HSPMC_BIT_CNT_W'(1);
          end
        end else begin
          nxt_st.tx_div = st_ff.tx_div - `HSPMC_DIV_W'(1);
        end
      end
      hspmc_pkg::HSPMC_SER_STOP: begin
        if (st_ff.tx_div == `HSPMC_DIV_W'(1)) begin
          nxt_st.tx_div = bit_div;
          if (st_ff.tx_cnt == `HSPMC_BIT_CNT_W'(0)) begin
            nxt_st.tx_st = hspmc_pkg::HSPMC_SER_IDLE;
          end else begin
            nxt_st.tx_cnt = st_ff.tx_cnt - `HSPMC_BIT_CNT_W'(1);
          end
        end else begin
          nxt_st.tx_div = st_ff.tx_div - `HSPMC_DIV_W'(1);
        end
      end
      default: begin
        nxt_st.tx_st = hspmc_pkg::HSPMC_SER_IDLE;
      end
    endcase
    // receiver from the terminal, sampled mid-bit
    case (st_ff.rx_st)
      hspmc_pkg::HSPMC_SER_IDLE: begin
        // only a live port may open a character
        if (port_on && !rx_in) begin
          nxt_st.rx_div = bit_div >> 1;
          nxt_st.rx_sel = use_p2;
          nxt_st.rx_st = hspmc_pkg::HSPMC_SER_START;
        end
      end
      hspmc_pkg::HSPMC_SER_START: begin
        if (st_ff.rx_div == `HSPMC_DIV_W'(1)) begin
          nxt_st.rx_div = bit_div;
          nxt_st.rx_cnt = `HSPMC_BIT_CNT_W'(`HSPMC_BITS);
          nxt_st.rx_st = rx_in ? hspmc_pkg::HSPMC_SER_IDLE : hspmc_pkg::HSPMC_SER_DATA;
        end else begin
          nxt_st.rx_div = st_ff.rx_div - `HSPMC_DIV_W'(1);
        end
      end
      hspmc_pkg::HSPMC_SER_DATA: begin
        if (st_ff.rx_div == `HSPMC_DIV_W'(1)) begin
          nxt_st.rx_div = bit_div;
          // bits arrive least significant first
          nxt_st.rx_sh = {rx_in, st_ff.rx_sh[7:1]};
          nxt_st.rx_cnt = st_ff.rx_cnt - `HSPMC_BIT_CNT_W'(1);
          if (st_ff.rx_cnt == `HSPMC_BIT_CNT_W'(1)) begin
            nxt_st.rx_st = hspmc_pkg::HSPMC_SER_STOP;
          end
        end else begin
          nxt_st.rx_div = st_ff.rx_div - `HSPMC_DIV_W'(1);
        end
      end
      hspmc_pkg::HSPMC_SER_STOP: begin
        if (st_ff.rx_div == `HSPMC_DIV_W'(1)) begin
          nxt_st.rx_st = hspmc_pkg::HSPMC_SER_IDLE;
          // a low stop bit flags a framing fault, the byte is kept
          nxt_st.rx_byte = st_ff.rx_sh;
          nxt_st.rx_valid = 1'b1;
          nxt_st.rx_err = !rx_in;
        end else begin
          nxt_st.rx_div = st_ff.rx_div - `HSPMC_DIV_W'(1);
        end
      end
      default: begin
        nxt_st.rx_st = hspmc_pkg::HSPMC_SER_IDLE;
      end
    endcase
    // a read of rx data clears valid, a new byte in the same cycle wins
    if (wb_req && !I_WB_WE && (I_WB_ADR == `HSPMC_ADR_RXD)
        && !(st_ff.rx_st == hspmc_pkg::HSPMC_SER_STOP && st_ff.rx_div == `HSPMC_DIV_W'(1))) begin
      nxt_st.rx_valid = 1'b0;
    end
    // port switch mid-character or standby aborts both directions
    if (standby || (st_ff.rx_st != hspmc_pkg::HSPMC_SER_IDLE && st_ff.rx_sel != use_p2)) begin
      nxt_st.rx_st = hspmc_pkg::HSPMC_SER_IDLE;
    end
    // a port switch mid-character cuts the rest of it
    if (st_ff.tx_st != hspmc_pkg::HSPMC_SER_IDLE && st_ff.tx_sel != use_p2) begin
      nxt_st.tx_st = hspmc_pkg::HSPMC_SER_IDLE;
      nxt_st.tx_line = 1'b1;
    end
    if (standby) begin
      nxt_st.tx_st = hspmc_pkg::HSPMC_SER_IDLE;
      nxt_st.tx_line = 1'b1;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  // serial lines leave reset at the idle level
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      st_ff <= '0;
      st_ff.ctrl <= `HSPMC_CTRL_RST;
      st_ff.feat <= `HSPMC_FEAT_RST;
      st_ff.tx_st <= hspmc_pkg::HSPMC_SER_IDLE;
      st_ff.rx_st <= hspmc_pkg::HSPMC_SER_IDLE;
      st_ff.tx_line <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************************
  // bus outputs
  // ************************************************************

  assign O_WB_ACK = st_ff.ack;
  assign O_WB_DAT = st_ff.rdat;
endmodule : hspmc_top

// File: test/hspmc_top_chk.sv
/*
  Port checker of the host serial port and mode control block.
  Assumes the top block's ports only; bound below its endmodule.
*/
`timescale 1ns/10ps
module hspmc_chk (
  input wire logic I_SYS_CLK,
  input wire logic I_NRST,
  input wire logic I_TERM_READY,
  input wire logic I_MODE_NPROG,
  input wire logic I_RSSI_ABOVE,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic O_WB_ACK,
  input wire logic O_RX_DATA_OUT_FIRST_PORT,
  input wire logic O_RX_DATA_OUT_SECOND_PORT,
  input wire logic O_CTS,
  input wire logic O_CD,
  input wire logic O_DSR
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_NRST);
  // ****************
  // properties
  // ****************
  property p_ack_pulse;
    O_WB_ACK |=> !O_WB_ACK;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack wider than one cycle");
  property p_ack_read;
    I_WB_CYC && I_WB_STB && !I_WB_WE && !O_WB_ACK |=> O_WB_ACK;
  endproperty
  a_ack_read: assert property (p_ack_read) else $error("read not answered next cycle");
  property p_stby_idle;
    !I_TERM_READY && $past(!I_TERM_READY)
      |-> O_RX_DATA_OUT_FIRST_PORT && O_RX_DATA_OUT_SECOND_PORT;
  endproperty
  a_stby_idle: assert property (p_stby_idle) else $error("line active in standby");
  property p_cts_stby;
    !I_TERM_READY |-> !O_CTS;
  endproperty
  a_cts_stby: assert property (p_cts_stby) else $error("clear shown in standby");
  property p_dsr;
    O_DSR == I_TERM_READY;
  endproperty
  a_dsr: assert property (p_dsr) else $error("ready output wrong");
  property p_cd;
    O_CD == (I_RSSI_ABOVE && I_TERM_READY);
  endproperty
  a_cd: assert property (p_cd) else $error("carrier output wrong");
  property p_one_port;
    O_RX_DATA_OUT_FIRST_PORT || O_RX_DATA_OUT_SECOND_PORT;
  endproperty
  a_one_port: assert property (p_one_port) else $error("both ports active");
  property p_prog_port;
    !I_MODE_NPROG && $past(!I_MODE_NPROG) |-> O_RX_DATA_OUT_SECOND_PORT;
  endproperty
  a_prog_port: assert property (p_prog_port) else $error("second port used in setup");
  c_ack: cover property (O_WB_ACK);
  c_stby: cover property (!I_TERM_READY);
  c_prog: cover property (!I_MODE_NPROG);
  c_char: cover property ($fell(O_RX_DATA_OUT_FIRST_PORT));
endmodule : hspmc_chk

bind hspmc_top hspmc_chk u_chk (.I_SYS_CLK, .I_NRST, .I_TERM_READY, .I_MODE_NPROG,
  .I_RSSI_ABOVE, .I_WB_CYC, .I_WB_STB, .I_WB_WE, .O_WB_ACK, .O_RX_DATA_OUT_FIRST_PORT,
  .O_RX_DATA_OUT_SECOND_PORT, .O_CTS, .O_CD, .O_DSR);

// File: test/hspmc_term_model.sv
/*
  Terminal model: sends and receives framed bytes on one port.
  Assumes one clock and a bit time given in clock cycles.
*/
`timescale 1ns/10ps
module hspmc_term_model #(
  parameter int BIT_CYC = 13020
) (
  input wire logic i_clk,
  input wire logic i_line_from_dce,
  output logic o_line_to_dce
);
  initial o_line_to_dce = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge i_clk);
      o_line_to_dce <= fr[i];
      repeat (BIT_CYC - 1) @(posedge i_clk);
    end
  endtask : send
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (i_line_from_dce !== 1'b0 && n < 20 * BIT_CYC) begin
      @(posedge i_clk);
      n++;
    end
    // sample mid-bit
    repeat (BIT_CYC / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge i_clk);
      b[i] = i_line_from_dce;
    end
    repeat (BIT_CYC) @(posedge i_clk);
    ok = (i_line_from_dce === 1'b1) && (n < 20 * BIT_CYC);
  endtask : recv
endmodule : hspmc_term_model

// File: test/hspmc_top_tb.sv
/*
  Self-checking bench of the host serial port and mode control block.
  Assumes hspmc_defs.svh on the include path and the terminal model.
*/
`timescale 1ns/10ps
`include "hspmc_defs.svh"
module hspmc_top_tb;
  logic clk, nrst, term_rdy, mode_nprog, rssi, rts, tx1, cyc, stb, we, narrow, strap;
  logic [3:0] adr;
  logic [31:0] wdat, dat_o, q;
  logic ack, rx1, rx2, cts, cd, dsr;
  int fails, tests_run;
  hspmc_top u_dut (.I_SYS_CLK(clk), .I_NRST(nrst), .I_TERM_READY(term_rdy),
    .I_MODE_NPROG(mode_nprog), .I_NARROW_CH(narrow), .I_PORT2_RS485(strap),
    .I_RSSI_ABOVE(rssi), .I_RTS(rts), .I_TX_DATA_IN_FIRST_PORT(tx1),
    .I_TX_DATA_IN_SECOND_PORT(1'b1), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat), .O_WB_DAT(dat_o), .O_WB_ACK(ack),
    .O_RX_DATA_OUT_FIRST_PORT(rx1), .O_RX_DATA_OUT_SECOND_PORT(rx2), .O_CTS(cts),
    .O_CD(cd), .O_DSR(dsr));
  hspmc_term_model #(.BIT_CYC(`HSPMC_DIV_FAST)) u_term (.i_clk(clk),
    .i_line_from_dce(rx1), .o_line_to_dce(tx1));
  // ****************
  // helpers
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic end_of_test;
    if (fails == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  // ****************
  // scenarios
  // ****************
  task automatic t_defaults;
    wb(1'b0, `HSPMC_ADR_CTRL, 32'h0);
    chk(q, 32'h00000011);
    wb(1'b0, `HSPMC_ADR_FEAT, 32'h0);
    chk(q, 32'h00000000);
    wb(1'b1, `HSPMC_ADR_STAT, 32'hFFFFFFFF);
    wb(1'b0, `HSPMC_ADR_STAT, 32'h0);
    chk(q, 32'h00000012);
    wb(1'b0, 4'hF, 32'h0);
    chk(q, 32'h00000000);
    wb(1'b1, `HSPMC_ADR_FEAT, 32'h0000007F);
    wb(1'b0, `HSPMC_ADR_FEAT, 32'h0);
    chk(q, 32'h0000007F);
    wb(1'b1, `HSPMC_ADR_FEAT, 32'h0);
  endtask : t_defaults
  task automatic t_handshake;
    logic [4:0] c;
    for (int p = 0; p < 3; p++) begin
      c = (p == 0) ? 5'h11 : ((p == 1) ? 5'h12 : 5'h09);
      wb(1'b1, `HSPMC_ADR_CTRL, {27'h0, c});
      for (int i = 0; i < 4; i++) begin
        @(posedge clk);
        rssi <= i[0];
        rts <= i[1];
        @(posedge clk);
        @(negedge clk);
        chk({cts, cd, dsr}, {(p == 2) ? i[1] : 1'b1, i[0], 1'b1});
      end
    end
    wb(1'b1, `HSPMC_ADR_CTRL, 32'h00000011);
  endtask : t_handshake
  task automatic t_prog;
    wb(1'b1, `HSPMC_ADR_CTRL, 32'h00000012);
    mode_nprog <= 1'b0;
    wb(1'b0, `HSPMC_ADR_STAT, 32'h0);
    chk(q, 32'h00000016);
    mode_nprog <= 1'b1;
    wb(1'b0, `HSPMC_ADR_STAT, 32'h0);
    chk(q, 32'h00000012);
    wb(1'b1, `HSPMC_ADR_CTRL, 32'h00000011);
  endtask : t_prog
  task automatic t_standby;
    rssi <= 1'b1;
    term_rdy <= 1'b0;
    wb(1'b0, `HSPMC_ADR_STAT, 32'h0);
    chk(q & 32'h00000008, 32'h00000008);
    chk({dsr, cd, cts, rx1, rx2}, 5'b00011);
    term_rdy <= 1'b1;
  endtask : t_standby
  task automatic t_serial;
    logic [7:0] b;
    logic ok;
    fork
      wb(1'b1, `HSPMC_ADR_TXD, 32'h000000A5);
      u_term.recv(b, ok);
    join
    chk({ok, b}, {1'b1, 8'hA5});
    u_term.send(8'h3C);
    wb(1'b0, `HSPMC_ADR_RXD, 32'h0);
    chk(q, 32'h0000003C);
    wb(1'b0, `HSPMC_ADR_STAT, 32'h0);
    chk(q & 32'h00000041, 32'h00000000);
  endtask : t_serial
  task automatic t_bit_time(input logic [4:0] c, input logic prog, input logic slow,
    input logic [31:0] exp);
    int n;
    logic p2;
    logic other_low;
    n = 0;
    other_low = 1'b0;
    p2 = !prog && (c == 5'h12);
    mode_nprog <= !prog;
    narrow <= slow;
    wb(1'b1, `HSPMC_ADR_CTRL, {27'h0, c});
    wb(1'b1, `HSPMC_ADR_TXD, 32'h00000001);
    while ((p2 ? rx2 : rx1) !== 1'b0) begin
      @(posedge clk);
    end
    while ((p2 ? rx2 : rx1) === 1'b0) begin
      other_low = other_low | ((p2 ? rx1 : rx2) === 1'b0);
      @(posedge clk);
      n++;
    end
    chk(n, exp);
    chk({31'h0, other_low}, 32'h00000000);
    term_rdy <= 1'b0;
    @(posedge clk);
    term_rdy <= 1'b1;
    mode_nprog <= 1'b1;
    narrow <= 1'b0;
    wb(1'b1, `HSPMC_ADR_CTRL, 32'h00000011);
  endtask : t_bit_time
  task automatic t_reset;
    wb(1'b1, `HSPMC_ADR_CTRL, 32'h0000001D);
    strap <= 1'b0;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    wb(1'b0, `HSPMC_ADR_CTRL, 32'h0);
    chk(q, 32'h00000011);
    wb(1'b0, `HSPMC_ADR_STAT, 32'h0);
    chk(q, 32'h00000002);
  endtask : t_reset
  // ****************
  // run
  // ****************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (800000) @(posedge clk);
    fails++;
    end_of_test();
  end
  initial begin
    {nrst, cyc, stb, we, rssi, rts, narrow} = 7'h00;
    {term_rdy, mode_nprog, strap} = 3'b111;
    adr = 4'h0;
    wdat = 32'h0;
    fails = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_defaults();
    t_handshake();
    t_prog();
    t_standby();
    t_serial();
    t_bit_time(5'h11, 1'b0, 1'b1, `HSPMC_DIV_SLOW);
    t_bit_time(5'h12, 1'b0, 1'b0, `HSPMC_DIV_FAST);
    t_bit_time(5'h12, 1'b1, 1'b0, `HSPMC_DIV_PROG);
    t_reset();
    end_of_test();
  end
endmodule : hspmc_top_tb
